// ==== rtl/ucs_map.vh ====
// Notes on behaviour
// (RULE1) rx rate upper nibble, tx lower, set bit
// (RULE2) several non-conflicting commands per write
// (RULE3) upper nibble one command, spaced accesses
// (RULE4) reset receiver or transmitter commands
// (RULE5) reset error status clears four bits
// (RULE6) reset break change flag
// (RULE7) start break once transmitter empty, enabled
// (RULE8) stop break, then one mark bit
// (RULE9) start counter/timer from preset
// (RULE10) stop counter, clear ready, output high
// (RULE11) request-to-send low/high, clear input change
// (RULE12) transmitter disable finishes queued characters
// (RULE13) transmitter enable sets ready flag
// (RULE14) receiver disable drops partial character
// (RULE15) receiver enable hunts for start bit
// (RULE16) status snapshot only while read idle
// (RULE17) break char, one entry, wait half bit
// (RULE18) framing error at stop; parity/address bit
// (RULE19) overrun loses waiting character
// (RULE20) transmitter empty set and clear conditions
// (RULE21) transmitter ready set and clear conditions
// (RULE22) receiver ready and fifo full flags
// (RULE23) command writes are one-cycle pulses
`ifndef UCS_MAP_VH
`define UCS_MAP_VH
// ****************************************
// register byte offsets
// ****************************************
`define UCS_OFF_CSEL 8'h00
`define UCS_OFF_CMD 8'h04
`define UCS_OFF_STAT 8'h08
`define UCS_OFF_AUX 8'h0C
`define UCS_OFF_THR 8'h10
`define UCS_OFF_RHR 8'h14
`define UCS_OFF_IFLAG 8'h18
`define UCS_OFF_CTH 8'h1C
`define UCS_OFF_CTL 8'h20
`define UCS_OFF_MODE 8'h24
// ****************************************
// command codes of the upper nibble
// ****************************************
`define UCS_CMD_MRPTR 4'h1
`define UCS_CMD_RXRST 4'h2
`define UCS_CMD_TXRST 4'h3
`define UCS_CMD_ERRRST 4'h4
`define UCS_CMD_BRKCLR 4'h5
`define UCS_CMD_BRKON 4'h6
`define UCS_CMD_BRKOFF 4'h7
`define UCS_CMD_CTGO 4'h8
`define UCS_CMD_CTSTOP 4'h9
`define UCS_CMD_RTSON 4'hA
`define UCS_CMD_RTSOFF 4'hB
`define UCS_CMD_MPICLR 4'hC
// ****************************************
// field positions
// ****************************************
`define UCS_CR_RXEN 0
`define UCS_CR_RXDIS 1
`define UCS_CR_TXEN 2
`define UCS_CR_TXDIS 3
`define UCS_ACR_BRGSET 7
`define UCS_ACR_CTMODE 6
`define UCS_MODE_PAREN 0
`define UCS_MODE_PARODD 1
`define UCS_MODE_WAKE 2
// ****************************************
// reset values and timing counts
// ****************************************
`define UCS_RST_BYTE 8'h00
`define UCS_RTS_RST 1'b1
`define UCS_BIT_LAST 4'hF
`define UCS_HALF_LAST 4'h7
`define UCS_CT_PRE_LAST 4'hF
`define UCS_FIFO_FULL 2'h3
`define UCS_CLK_HZ 64'd250000000
`define UCS_RESP_OK 2'h0
`define UCS_RESP_ERR 2'h2
`endif

// ==== rtl/ucs_rate_gen.v ====
`timescale 1ns/1ps
`include "ucs_map.vh"
module ucs_rate_gen (
	input wire sys_clk,
	input wire rst,
	input wire [3:0] rateCode,
	input wire rateSet,
	input wire timerTick,
	input wire mpiTick,
	output reg tick16
);
	// ****************************************
	// rate table, baud in tenths
	// ****************************************
	function [19:0] baudTenths;
		input [3:0] c;
		input s;
		begin
			case (c)
				4'h0: baudTenths = s ? 20'h002EE : 20'h001F4;
				4'h1: baudTenths = 20'h0044C;
				4'h2: baudTenths = 20'h00541;
				4'h3: baudTenths = s ? 20'h005DC : 20'h007D0;
				4'h4: baudTenths = 20'h00BB8;
				4'h5: baudTenths = 20'h01770;
				4'h6: baudTenths = 20'h02EE0;
				4'h7: baudTenths = s ? 20'h04E20 : 20'h02904;
				4'h8: baudTenths = 20'h05DC0;
				4'h9: baudTenths = 20'h0BB80;
				4'hA: baudTenths = s ? 20'h04650 : 20'h11940;
				4'hB: baudTenths = 20'h17700;
				4'hC: baudTenths = s ? 20'h2EE00 : 20'h5DC00;
				default: baudTenths = 20'h00001;
			endcase
		end
	endfunction
	wire [63:0] divFull = (`UCS_CLK_HZ * 64'd10) / ({44'h0, baudTenths(rateCode, rateSet)} * 64'd16);
	wire [19:0] divLast = divFull[19:0] - 20'h1;
	reg [19:0] cnt_q;
	// ****************************************
	// divider or external sixteen-times source
	// ****************************************
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			cnt_q <= 20'h0;
			tick16 <= 1'b0;
		end
		else if (rateCode == 4'hD)
			tick16 <= timerTick;
		else if (rateCode[3:1] == 3'h7)
			tick16 <= mpiTick;
		else if (cnt_q >= divLast)
		begin
			cnt_q <= 20'h0;
			tick16 <= 1'b1;
		end
		else
		begin
			cnt_q <= cnt_q + 20'h1;
			tick16 <= 1'b0;
		end
	end
endmodule

// ==== rtl/ucs_uart_core.v ====
`timescale 1ns/1ps
`include "ucs_map.vh"
module ucs_uart_core (
	input wire sys_clk,
	input wire rst,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	input wire rxdIn,
	output reg txdOut,
	input wire mpiIn,
	output reg mpoOut
);
	localparam RX_IDLE = 4'b0001;
	localparam RX_START = 4'b0010;
	localparam RX_DATA = 4'b0100;
	localparam RX_BRK = 4'b1000;
	localparam TX_IDLE = 4'b0001;
	localparam TX_SHIFT = 4'b0010;
	localparam TX_BREAK = 4'b0100;
	localparam TX_MARK = 4'b1000;

	// ****************************************
	// address decode
	// ****************************************
	function mapped;
		input [7:0] a;
		input wr;
		begin
			case (a)
				`UCS_OFF_CSEL, `UCS_OFF_CMD, `UCS_OFF_AUX, `UCS_OFF_THR, `UCS_OFF_CTH, `UCS_OFF_CTL: mapped = wr;
				`UCS_OFF_STAT, `UCS_OFF_RHR, `UCS_OFF_IFLAG: mapped = !wr;
				`UCS_OFF_MODE: mapped = 1'b1;
				default: mapped = 1'b0;
			endcase
		end
	endfunction

	reg awHave_q, wHave_q, wStrb_q;
	reg [7:0] awAddr_q, wData_q;
	reg [7:0] csel_q, aux_q, ctHi_q, ctLo_q;
	reg [2:0] mode_q;
	reg mrPtr_q;
	reg [7:0] statSnap_q;
	reg rxEn_q, errB_q, errF_q, errP_q, ovr_q, brkChg_q;
	reg [3:0] rxSt_q, rxTick_q, rxBit_q;
	reg [8:0] rxSh_q;
	reg [10:0] fifo_q [0:2];
	reg [1:0] fifoCnt_q;
	reg heldV_q;
	reg [10:0] held_q;
	reg txEn_q, txPend_q, thrV_q, transmitter_ready_flag_q, transmitter_empty_flag_q, brkReq_q;
	reg [7:0] thr_q;
	reg [3:0] txSt_q, txTick_q, txBit_q;
	reg [10:0] txSh_q;
	reg [15:0] ctCnt_q;
	reg [3:0] ctPre_q;
	reg ctRun_q, ctStop_q, ctOut_q, ctRdy_q, ctHalf_q, ctTick_q;
	reg mpiPrev_q, mpiChg_q, rtsLevel_q;
	wire rxTick, txTick;
	integer i;

	// ****************************************
	// write decode into one-cycle pulses
	// ****************************************
	wire wrFire = awHave_q && wHave_q && !s_axi_bvalid;
	wire wrGo = wrFire && wStrb_q;
	wire cmdGo = wrGo && awAddr_q == `UCS_OFF_CMD; // RULE23
	wire [3:0] cmd = cmdGo ? wData_q[7:4] : 4'h0; // RULE3
	wire rxEnCmd = cmdGo && wData_q[`UCS_CR_RXEN]; // RULE2
	wire rxDisCmd = cmdGo && wData_q[`UCS_CR_RXDIS];
	wire txEnCmd = cmdGo && wData_q[`UCS_CR_TXEN];
	wire txDisCmd = cmdGo && wData_q[`UCS_CR_TXDIS];
	wire thrWr = wrGo && awAddr_q == `UCS_OFF_THR;
	wire rdPop = s_axi_arvalid && s_axi_arready && s_axi_araddr == `UCS_OFF_RHR && fifoCnt_q != 2'h0;
	wire wake = mode_q[`UCS_MODE_WAKE];
	wire parEn = mode_q[`UCS_MODE_PAREN];
	wire ctTimer = aux_q[`UCS_ACR_CTMODE];
	wire receiver_ready_flag = fifoCnt_q != 2'h0;
	wire fifo_full_flag = fifoCnt_q == `UCS_FIFO_FULL;
	wire [7:0] statNow = {errB_q, errF_q, errP_q, ovr_q, transmitter_empty_flag_q, transmitter_ready_flag_q, fifo_full_flag, receiver_ready_flag};
	wire [7:0] iflag = {mpiChg_q, mpiPrev_q, 1'b0, ctRdy_q, brkChg_q, receiver_ready_flag, transmitter_empty_flag_q, transmitter_ready_flag_q};

	// ****************************************
	// baud clocks
	// ****************************************
	ucs_rate_gen rxRate (
		.sys_clk(sys_clk),
		.rst(rst),
		.rateCode(csel_q[7:4]), // RULE1
		.rateSet(aux_q[`UCS_ACR_BRGSET]),
		.timerTick(ctTick_q),
		.mpiTick(mpiIn && !mpiPrev_q),
		.tick16(rxTick)
	);
	ucs_rate_gen txRate (
		.sys_clk(sys_clk),
		.rst(rst),
		.rateCode(csel_q[3:0]), // RULE1
		.rateSet(aux_q[`UCS_ACR_BRGSET]),
		.timerTick(ctTick_q),
		.mpiTick(mpiIn && !mpiPrev_q),
		.tick16(txTick)
	);

	// ****************************************
	// bus slave
	// ****************************************
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `UCS_RESP_OK;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `UCS_RESP_OK;
			s_axi_rdata <= 32'h0;
			awHave_q <= 1'b0;
			wHave_q <= 1'b0;
			awAddr_q <= 8'h00;
			wData_q <= 8'h00;
			wStrb_q <= 1'b0;
			statSnap_q <= 8'h00;
		end
		else
		begin
			s_axi_awready <= s_axi_awvalid && !awHave_q && !s_axi_awready;
			s_axi_wready <= s_axi_wvalid && !wHave_q && !s_axi_wready;
			if (s_axi_awvalid && !awHave_q && !s_axi_awready)
			begin
				awHave_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !wHave_q && !s_axi_wready)
			begin
				wHave_q <= 1'b1;
				wData_q <= s_axi_wdata[7:0];
				wStrb_q <= s_axi_wstrb[0];
			end
			if (wrFire)
			begin
				awHave_q <= 1'b0;
				wHave_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= mapped(awAddr_q, 1'b1) ? `UCS_RESP_OK : `UCS_RESP_ERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
			s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= mapped(s_axi_araddr, 1'b0) ? `UCS_RESP_OK : `UCS_RESP_ERR;
				case (s_axi_araddr)
					`UCS_OFF_STAT: s_axi_rdata <= {24'h0, statSnap_q};
					`UCS_OFF_RHR: s_axi_rdata <= {24'h0, fifo_q[0][7:0]};
					`UCS_OFF_IFLAG: s_axi_rdata <= {24'h0, iflag};
					`UCS_OFF_MODE: s_axi_rdata <= {24'h0, mrPtr_q, 4'h0, mode_q};
					default: s_axi_rdata <= 32'h0;
				endcase
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
			// status frozen while a read is under way
			if (!s_axi_arvalid && !s_axi_rvalid)
				statSnap_q <= statNow; // RULE16
		end
	end

	// ****************************************
	// plain control registers
	// ****************************************
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			csel_q <= `UCS_RST_BYTE;
			aux_q <= `UCS_RST_BYTE;
			ctHi_q <= `UCS_RST_BYTE;
			ctLo_q <= `UCS_RST_BYTE;
			mode_q <= 3'h0;
			mrPtr_q <= 1'b0;
			rtsLevel_q <= `UCS_RTS_RST;
			mpiPrev_q <= mpiIn; // no false edge after reset
			mpiChg_q <= 1'b0;
		end
		else
		begin
			if (wrGo && awAddr_q == `UCS_OFF_CSEL)
				csel_q <= wData_q;
			if (wrGo && awAddr_q == `UCS_OFF_AUX)
				aux_q <= wData_q;
			if (wrGo && awAddr_q == `UCS_OFF_CTH)
				ctHi_q <= wData_q;
			if (wrGo && awAddr_q == `UCS_OFF_CTL)
				ctLo_q <= wData_q;
			if (wrGo && awAddr_q == `UCS_OFF_MODE)
			begin
				mode_q <= wData_q[2:0];
				mrPtr_q <= 1'b1;
			end
			else if (cmd == `UCS_CMD_MRPTR)
				mrPtr_q <= 1'b0; // RULE3
			if (cmd == `UCS_CMD_RTSON)
				rtsLevel_q <= 1'b0; // RULE11
			else if (cmd == `UCS_CMD_RTSOFF)
				rtsLevel_q <= 1'b1; // RULE11
			mpiPrev_q <= mpiIn;
			mpiChg_q <= (mpiChg_q && cmd != `UCS_CMD_MPICLR) || (mpiIn != mpiPrev_q); // RULE11
		end
	end

	// ****************************************
	// receiver framing
	// ****************************************
	wire [7:0] rxData = parEn ? rxSh_q[7:0] : rxSh_q[8:1];
	wire rxPar = (^rxSh_q) ^ mode_q[`UCS_MODE_PARODD];
	wire rxStopBit = rxSt_q == RX_DATA && rxTick && rxTick_q == `UCS_BIT_LAST && rxBit_q == {3'h4, parEn};
	wire rxBrkNow = rxStopBit && !rxdIn && ~|rxData && !(parEn && rxSh_q[8]);
	wire rxDone = rxStopBit && (rxEn_q || wake);
	wire [10:0] rxWord = {rxBrkNow, !rxdIn, wake ? rxSh_q[8] : (parEn && rxPar), rxData}; // RULE18
	always @(posedge sys_clk)
	begin
		if (rst || cmd == `UCS_CMD_RXRST)
		begin
			rxSt_q <= RX_IDLE; // RULE4
			rxEn_q <= 1'b0;
			rxTick_q <= 4'h0;
			rxBit_q <= 4'h0;
			rxSh_q <= 9'h0;
		end
		else if (rxEnCmd && !wake)
		begin
			rxEn_q <= 1'b1;
			rxSt_q <= RX_IDLE; // RULE15
		end
		else if (rxDisCmd && !wake)
		begin
			rxEn_q <= 1'b0;
			rxSt_q <= RX_IDLE; // RULE14
		end
		else
		begin
			if (rxEnCmd)
				rxEn_q <= 1'b1;
			if (rxDisCmd)
				rxEn_q <= 1'b0;
			if (rxTick && (rxEn_q || wake))
			begin
				rxTick_q <= rxTick_q + 4'h1;
				case (rxSt_q)
					RX_IDLE:
					begin
						rxTick_q <= 4'h0;
						if (!rxdIn)
							rxSt_q <= RX_START;
					end
					RX_START:
						if (rxTick_q == `UCS_HALF_LAST)
						begin
							rxTick_q <= 4'h0;
							rxBit_q <= 4'h0;
							rxSt_q <= rxdIn ? RX_IDLE : RX_DATA;
						end
					RX_DATA:
						if (rxTick_q == `UCS_BIT_LAST)
						begin
							rxBit_q <= rxBit_q + 4'h1;
							rxSh_q <= {rxdIn, rxSh_q[8:1]};
							if (rxStopBit)
							begin
								rxSt_q <= rxBrkNow ? RX_BRK : RX_IDLE; // RULE17
								rxSh_q <= rxSh_q;
							end
						end
					RX_BRK:
					begin
						// line must mark for half a bit
						if (!rxdIn)
							rxTick_q <= 4'h0;
						else if (rxTick_q == `UCS_HALF_LAST)
							rxSt_q <= RX_IDLE; // RULE17
					end
					default: rxSt_q <= RX_IDLE;
				endcase
			end
		end
	end

	// ****************************************
	// receive fifo, waiting char and flags
	// ****************************************
	wire room = !fifo_full_flag || rdPop;
	wire pushHeld = heldV_q && room;
	wire pushNew = rxDone && !heldV_q && room;
	wire [10:0] pushWord = heldV_q ? held_q : rxWord;
	wire [1:0] pushIdx = fifoCnt_q - {1'b0, rdPop};
	wire brkEnd = rxSt_q == RX_BRK && rxTick && rxdIn && rxTick_q == `UCS_HALF_LAST;
	always @(posedge sys_clk)
	begin
		if (rst || cmd == `UCS_CMD_RXRST)
		begin
			fifoCnt_q <= 2'h0; // RULE4
			heldV_q <= 1'b0;
			held_q <= 11'h0;
			for (i = 0; i < 3; i = i + 1)
				fifo_q[i] <= 11'h0;
		end
		else
		begin
			if (rdPop)
			begin
				fifo_q[0] <= fifo_q[1];
				fifo_q[1] <= fifo_q[2];
			end
			if (pushHeld || pushNew)
				fifo_q[pushIdx] <= pushWord; // RULE22
			fifoCnt_q <= pushIdx + {1'b0, pushHeld || pushNew}; // RULE22
			if (rxDone && (heldV_q || !room))
			begin
				heldV_q <= 1'b1;
				held_q <= rxWord; // RULE19
			end
			else if (pushHeld)
				heldV_q <= 1'b0;
		end
	end
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			errB_q <= 1'b0;
			errF_q <= 1'b0;
			errP_q <= 1'b0;
			ovr_q <= 1'b0;
			brkChg_q <= 1'b0;
		end
		else
		begin
			// set wins over the reset-error command
			errB_q <= (errB_q && cmd != `UCS_CMD_ERRRST) || ((pushHeld || pushNew) && pushWord[10]); // RULE5
			errF_q <= (errF_q && cmd != `UCS_CMD_ERRRST) || ((pushHeld || pushNew) && pushWord[9]); // RULE5
			errP_q <= (errP_q && cmd != `UCS_CMD_ERRRST) || ((pushHeld || pushNew) && pushWord[8]); // RULE5
			ovr_q <= (ovr_q && cmd != `UCS_CMD_ERRRST) || (rxDone && heldV_q && !room); // RULE19
			brkChg_q <= (brkChg_q && cmd != `UCS_CMD_BRKCLR) || (rxDone && rxBrkNow) || brkEnd; // RULE6
		end
	end

	// ****************************************
	// transmitter
	// ****************************************
	wire [10:0] txFrame = {1'b1, parEn ? (^thr_q) ^ mode_q[`UCS_MODE_PARODD] : 1'b1, thr_q, 1'b0};
	wire txBitEnd = txTick && txTick_q == `UCS_BIT_LAST;
	wire txLast = txBitEnd && txBit_q == (parEn ? 4'hA : 4'h9); // stop bit done
	always @(posedge sys_clk)
	begin
		if (rst || cmd == `UCS_CMD_TXRST)
		begin
			txEn_q <= 1'b0; // RULE4
			txPend_q <= 1'b0;
			thrV_q <= 1'b0;
			thr_q <= 8'h00;
			transmitter_ready_flag_q <= 1'b0;
			transmitter_empty_flag_q <= 1'b0; // RULE20
			brkReq_q <= 1'b0;
			txSt_q <= TX_IDLE;
			txTick_q <= 4'h0;
			txBit_q <= 4'h0;
			txSh_q <= 11'h7FF;
			txdOut <= 1'b1;
		end
		else
		begin
			txdOut <= txSt_q == TX_SHIFT ? txSh_q[0] : txSt_q != TX_BREAK;
			if (txEnCmd)
			begin
				txEn_q <= 1'b1;
				txPend_q <= 1'b0;
				if (!txEn_q)
				begin
					transmitter_ready_flag_q <= 1'b1; // RULE13
					transmitter_empty_flag_q <= 1'b1; // RULE20
				end
			end
			if (txDisCmd)
			begin
				txEn_q <= 1'b0;
				transmitter_ready_flag_q <= 1'b0; // RULE21
				transmitter_empty_flag_q <= 1'b0; // RULE12
				txPend_q <= thrV_q || txSt_q == TX_SHIFT; // RULE12
			end
			if (thrWr && txEn_q)
			begin
				thr_q <= wData_q; // RULE12
				thrV_q <= 1'b1;
				transmitter_ready_flag_q <= 1'b0; // RULE21
				transmitter_empty_flag_q <= 1'b0; // RULE20
			end
			if (cmd == `UCS_CMD_BRKON)
				brkReq_q <= 1'b1;
			if (cmd == `UCS_CMD_BRKOFF)
				brkReq_q <= 1'b0;
			if (txTick)
				txTick_q <= txTick_q + 4'h1;
			case (txSt_q)
				TX_IDLE:
				begin
					if (thrV_q && (txEn_q || txPend_q) && !thrWr)
					begin
						txSh_q <= txFrame;
						thrV_q <= 1'b0;
						transmitter_ready_flag_q <= txEn_q; // RULE21
						txTick_q <= 4'h0;
						txBit_q <= 4'h0;
						txSt_q <= TX_SHIFT;
					end
					else if (brkReq_q && txEn_q && transmitter_empty_flag_q && cmd != `UCS_CMD_BRKOFF)
						txSt_q <= TX_BREAK; // RULE7
				end
				TX_SHIFT:
					if (txBitEnd)
					begin
						txSh_q <= {1'b1, txSh_q[10:1]};
						txBit_q <= txBit_q + 4'h1;
						if (txLast)
						begin
							txSt_q <= TX_IDLE;
							if (!thrV_q)
							begin
								txPend_q <= 1'b0; // RULE12
								transmitter_empty_flag_q <= txEn_q && !thrWr; // RULE20
							end
						end
					end
				TX_BREAK:
					if (cmd == `UCS_CMD_BRKOFF || !brkReq_q)
					begin
						txTick_q <= 4'h0;
						txSt_q <= TX_MARK; // RULE8
					end
				TX_MARK:
					if (txBitEnd)
						txSt_q <= TX_IDLE; // RULE8
				default: txSt_q <= TX_IDLE;
			endcase
		end
	end

	// ****************************************
	// counter/timer and multipurpose output
	// ****************************************
	wire ctGo = cmd == `UCS_CMD_CTGO && (ctTimer || ctStop_q);
	wire ctEdge = ctPre_q == `UCS_CT_PRE_LAST;
	always @(posedge sys_clk)
	begin
		if (rst)
		begin
			ctCnt_q <= 16'h0;
			ctPre_q <= 4'h0;
			ctRun_q <= 1'b0;
			ctStop_q <= 1'b1;
			ctOut_q <= 1'b1;
			ctRdy_q <= 1'b0;
			ctHalf_q <= 1'b0;
			ctTick_q <= 1'b0;
			mpoOut <= `UCS_RTS_RST;
		end
		else
		begin
			ctPre_q <= ctPre_q + 4'h1;
			ctTick_q <= 1'b0;
			if (ctGo)
			begin
				ctCnt_q <= {ctHi_q, ctLo_q}; // RULE9
				ctRun_q <= 1'b1;
				ctStop_q <= 1'b0;
				ctHalf_q <= 1'b0;
				ctOut_q <= 1'b1;
			end
			else if (ctRun_q && ctEdge)
			begin
				ctCnt_q <= ctCnt_q - 16'h1;
				if (ctCnt_q == 16'h0 && ctTimer)
				begin
					ctCnt_q <= {ctHi_q, ctLo_q};
					ctOut_q <= !ctOut_q;
					ctHalf_q <= !ctHalf_q;
					ctTick_q <= 1'b1;
				end
				else if (ctCnt_q == 16'h1 && !ctTimer)
					ctOut_q <= 1'b0;
			end
			if (cmd == `UCS_CMD_CTSTOP && !ctTimer)
			begin
				ctRun_q <= 1'b0; // RULE10
				ctStop_q <= 1'b1;
				ctOut_q <= 1'b1; // RULE10
			end
			if (ctRun_q && ctEdge && ((ctTimer && ctCnt_q == 16'h0 && ctHalf_q) || (!ctTimer && ctCnt_q == 16'h1)))
				ctRdy_q <= 1'b1;
			else if (cmd == `UCS_CMD_CTSTOP)
				ctRdy_q <= 1'b0; // RULE10
			case (aux_q[2:0])
				3'h0: mpoOut <= rtsLevel_q; // RULE11
				3'h1: mpoOut <= ctOut_q;
				3'h2, 3'h3: mpoOut <= txTick;
				3'h4, 3'h5: mpoOut <= rxTick;
				3'h6: mpoOut <= !transmitter_ready_flag_q;
				default: mpoOut <= !receiver_ready_flag;
			endcase
		end
	end
endmodule

// ==== testbench/ucs_uart_core_asserts.sv ====
`timescale 1ns/1ps
`include "ucs_map.vh"
module ucs_uart_core_asserts (
	input wire sys_clk,
	input wire rst,
	input wire [7:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [1:0] s_axi_bresp,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [7:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire [1:0] s_axi_rresp,
	input wire s_axi_rvalid,
	input wire s_axi_rready
);
// ****************************************
// register bus timing
// ****************************************
default clocking cb @(posedge sys_clk); endclocking
default disable iff (rst);
sequence s_aw_take;
	s_axi_awvalid && s_axi_awready;
endsequence
sequence s_ar_take;
	s_axi_arvalid && s_axi_arready;
endsequence
property p_aw_pulse;
	s_axi_awready |=> !s_axi_awready;
endproperty
a_aw_pulse: assert property (p_aw_pulse) else $error("awready held");
property p_ar_pulse;
	s_axi_arready |=> !s_axi_arready;
endproperty
a_ar_pulse: assert property (p_ar_pulse) else $error("arready held");
property p_b_hold;
	s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
endproperty
a_b_hold: assert property (p_b_hold) else $error("write response dropped");
property p_r_hold;
	s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
endproperty
a_r_hold: assert property (p_r_hold) else $error("read data changed");
property p_r_answer;
	s_ar_take |-> ##[1:2] (s_axi_rvalid && s_axi_rdata[31:8] == 24'h0);
endproperty
a_r_answer: assert property (p_r_answer) else $error("late read answer");
property p_w_answer;
	s_aw_take |-> ##[0:3] s_axi_bvalid;
endproperty
a_w_answer: assert property (p_w_answer) else $error("late write answer");
property p_wr_err;
	s_aw_take and (s_axi_awaddr[7:2] > 6'h09) |-> ##[0:3] (s_axi_bvalid && s_axi_bresp == `UCS_RESP_ERR);
endproperty
a_wr_err: assert property (p_wr_err) else $error("unmapped write accepted");
property p_rd_err;
	s_ar_take and (s_axi_araddr[7:2] > 6'h09) |-> ##[1:2] (s_axi_rresp == `UCS_RESP_ERR && s_axi_rdata == 32'h0);
endproperty
a_rd_err: assert property (p_rd_err) else $error("unmapped read accepted");
property p_no_aw_in_b;
	s_axi_bvalid && $past(s_axi_bvalid) |-> !s_axi_awready;
endproperty
a_no_aw_in_b: assert property (p_no_aw_in_b) else $error("write taken during response");
property p_cmd_ok;
	s_aw_take and (s_axi_awaddr == `UCS_OFF_CMD) |-> ##[0:3] (s_axi_bvalid && s_axi_bresp == `UCS_RESP_OK);
endproperty
a_cmd_ok: assert property (p_cmd_ok) else $error("command write refused");
endmodule
bind ucs_uart_core ucs_uart_core_asserts ucs_uart_core_asserts_inst (
	.sys_clk(sys_clk),
	.rst(rst),
	.s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready),
	.s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready),
	.s_axi_araddr(s_axi_araddr),
	.s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready),
	.s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp),
	.s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready)
);

// ==== testbench/ucs_far_end.sv ====
`timescale 1ns/1ps
module ucs_far_end #(
	parameter int BIT_CYC = 6512
) (
	input wire logic sys_clk,
	input wire logic txdOut,
	input wire logic sendGo,
	input wire logic [7:0] sendByte,
	input wire logic badStop,
	output logic rxdIn,
	output logic [7:0] rxByte,
	output logic [7:0] rxCnt
);
// ****************************************
// remote serial end
// ****************************************
// sender: start, 8 bits lsb first, stop
initial
begin
	logic [9:0] frame;
	rxdIn = 1'b1;
	forever
	begin
		@(posedge sys_clk);
		if (sendGo)
		begin
			frame = {~badStop, sendByte, 1'b0};
			for (int i = 0; i < 10; i++)
			begin
				rxdIn <= frame[i];
				repeat (BIT_CYC) @(posedge sys_clk);
			end
			rxdIn <= 1'b1; // back to mark
		end
	end
end
// receiver: samples mid-bit, waits for mark after each frame
initial
begin
	logic [7:0] sh;
	rxCnt = 8'h00;
	rxByte = 8'h00;
	forever
	begin
		@(posedge sys_clk);
		if (txdOut === 1'b0)
		begin
			repeat (BIT_CYC / 2) @(posedge sys_clk);
			for (int i = 0; i < 8; i++)
			begin
				repeat (BIT_CYC) @(posedge sys_clk);
				sh[i] = txdOut;
			end
			repeat (BIT_CYC) @(posedge sys_clk);
			rxByte <= sh;
			rxCnt <= rxCnt + 8'h01;
			while (txdOut !== 1'b1) @(posedge sys_clk);
		end
	end
end
endmodule

// ==== testbench/uart_command_status_logic_tb.sv ====
`timescale 1ns/1ps
`include "ucs_map.vh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("Error %0t: got %h exp %h", $time, g, e); end end
module uart_command_status_logic_tb;
localparam int BIT = 6496; // 16 ticks of 406 cycles
localparam logic [1:0] rOk = `UCS_RESP_OK;
localparam logic [1:0] rErr = `UCS_RESP_ERR;
logic sys_clk = 1'b0;
logic rst = 1'b1;
logic [7:0] awAddr = 8'h00;
logic [7:0] arAddr = 8'h00;
logic [31:0] wData = 32'h0;
logic [3:0] wStrb = 4'hF;
logic awValid = 1'b0;
logic wValid = 1'b0;
logic bReady = 1'b0;
logic arValid = 1'b0;
logic rReady = 1'b0;
logic mpiIn = 1'b0;
logic sendGo = 1'b0;
logic badStop = 1'b1;
logic [7:0] sendByte = 8'h00;
logic [7:0] rdVal, txB, rxB;
logic [1:0] rdResp;
wire awReady, wReady, bValid, arReady, rValid, rxdIn, txdOut, mpoOut;
wire [1:0] bResp, rResp;
wire [31:0] rData;
wire [7:0] farByte, farCnt;
int error_cnt = 0;
int compares = 0;
logic [3:0] codes [6] = '{4'hC, 4'hD, 4'hE, 4'hF, 4'h5, 4'h8};
ucs_uart_core ucs_uart_core_inst (
	.sys_clk(sys_clk), .rst(rst),
	.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
	.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
	.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
	.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
	.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
	.rxdIn(rxdIn), .txdOut(txdOut), .mpiIn(mpiIn), .mpoOut(mpoOut)
);
ucs_far_end #(.BIT_CYC(BIT)) ucs_far_end_inst (
	.sys_clk(sys_clk), .txdOut(txdOut), .sendGo(sendGo), .sendByte(sendByte),
	.badStop(badStop), .rxdIn(rxdIn), .rxByte(farByte), .rxCnt(farCnt)
);
// ****************************************
// clock, watchdog and bus tasks
// ****************************************
initial forever #2 sys_clk = ~sys_clk;
// cuts a hang short
initial
begin
	repeat (90000) @(posedge sys_clk);
	error_cnt++;
	$display("Error %0t: timeout", $time);
	print_verdict;
end
// expected status byte
function automatic logic [7:0] expStat(input logic fe, input logic txOn, input logic receiver_ready_flag);
	return {1'b0, fe, 2'b00, txOn, txOn, 1'b0, receiver_ready_flag};
endfunction
task automatic print_verdict;
	$display("compares %0d errors %0d", compares, error_cnt);
	if (error_cnt == 0 && compares > 0)
		$display("== PASSED ==");
	else
		$display("== FAILED ==");
	$finish;
endtask
task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] e);
	repeat (4) @(posedge sys_clk);
	awAddr <= a;
	wData <= {24'h0, v};
	awValid <= 1'b1;
	wValid <= 1'b1;
	bReady <= 1'b1;
	forever
	begin
		@(posedge sys_clk);
		if (awReady) awValid <= 1'b0;
		if (wReady) wValid <= 1'b0;
		if (bValid) break;
	end
	`CHK(bResp, e)
	bReady <= 1'b0;
endtask
task automatic rdChk(input logic [7:0] a, input logic [7:0] x, input logic [1:0] e);
	repeat (4) @(posedge sys_clk);
	arAddr <= a;
	arValid <= 1'b1;
	rReady <= 1'b1;
	forever
	begin
		@(posedge sys_clk);
		if (arReady) arValid <= 1'b0;
		if (rValid) break;
	end
	rdVal = rData[7:0];
	rdResp = rResp;
	rReady <= 1'b0;
	`CHK(rdVal, x)
	`CHK(rdResp, e)
endtask
// ****************************************
// main sequence
// ****************************************
initial
begin
	int seed;
	seed = $urandom(78445);
	repeat (20) @(posedge sys_clk);
	rst <= 1'b0;
	rdChk(`UCS_OFF_STAT, 8'h00, rOk);
	rdChk(8'h30, 8'h00, rErr);
	wr(`UCS_OFF_STAT, 8'hFF, rErr);
	wr(8'h30, 8'h00, rErr);
	wr(`UCS_OFF_MODE, 8'h00, rOk);
	rdChk(`UCS_OFF_MODE, 8'h80, rOk);
	wr(`UCS_OFF_CMD, {`UCS_CMD_MRPTR, 4'h0}, rOk);
	rdChk(`UCS_OFF_MODE, 8'h00, rOk);
	wr(`UCS_OFF_CSEL, 8'hCC, rOk);
	wr(`UCS_OFF_AUX, 8'h00, rOk);
	wr(`UCS_OFF_CMD, 8'hA5, rOk);
	repeat (3) @(posedge sys_clk);
	`CHK(mpoOut, 1'b0)
	rdChk(`UCS_OFF_STAT, expStat(1'b0, 1'b1, 1'b0), rOk);
	wr(`UCS_OFF_CMD, 8'h30, rOk);
	rdChk(`UCS_OFF_STAT, 8'h00, rOk);
	wr(`UCS_OFF_CMD, 8'hB4, rOk);
	repeat (3) @(posedge sys_clk);
	`CHK(mpoOut, 1'b1)
	txB = 8'($urandom);
	rxB = 8'($urandom) | 8'h01;
	wr(`UCS_OFF_THR, txB, rOk);
	sendByte <= rxB;
	sendGo <= 1'b1;
	@(posedge sys_clk);
	sendGo <= 1'b0;
	rdChk(`UCS_OFF_STAT, 8'h04, rOk);
	wr(`UCS_OFF_CMD, 8'h08, rOk);
	rdChk(`UCS_OFF_STAT, 8'h00, rOk);
	for (int n = 0; n < 12 * BIT && farCnt == 8'h00; n++) @(posedge sys_clk);
	`CHK(farByte, txB)
	repeat (BIT) @(posedge sys_clk);
	rdChk(`UCS_OFF_STAT, expStat(1'b1, 1'b0, 1'b1), rOk);
	rdChk(`UCS_OFF_RHR, rxB, rOk);
	rdChk(`UCS_OFF_STAT, expStat(1'b1, 1'b0, 1'b0), rOk);
	wr(`UCS_OFF_CMD, {`UCS_CMD_ERRRST, 4'h0}, rOk);
	rdChk(`UCS_OFF_STAT, 8'h00, rOk);
	wr(`UCS_OFF_THR, ~txB, rOk);
	wr(`UCS_OFF_CMD, 8'h04, rOk);
	rdChk(`UCS_OFF_STAT, 8'h0C, rOk);
	`CHK(txdOut, 1'b1)
	wr(`UCS_OFF_CMD, {`UCS_CMD_BRKON, 4'h0}, rOk);
	for (int n = 0; n < 2 * BIT && txdOut !== 1'b0; n++) @(posedge sys_clk);
	`CHK(txdOut, 1'b0)
	wr(`UCS_OFF_CMD, {`UCS_CMD_BRKOFF, 4'h0}, rOk);
	for (int n = 0; n < 2 * BIT && txdOut !== 1'b1; n++) @(posedge sys_clk);
	`CHK(txdOut, 1'b1)
	wr(`UCS_OFF_AUX, 8'h01, rOk);
	mpiIn <= 1'b1;
	wr(`UCS_OFF_CTL, 8'h02, rOk);
	foreach (codes[i]) wr(`UCS_OFF_CMD, {codes[i], 4'h0}, rOk);
	repeat (40) @(posedge sys_clk);
	`CHK(mpoOut, 1'b0)
	rdChk(`UCS_OFF_IFLAG, 8'h53, rOk);
	wr(`UCS_OFF_CMD, {`UCS_CMD_CTSTOP, 4'h0}, rOk);
	repeat (3) @(posedge sys_clk);
	`CHK(mpoOut, 1'b1)
	rdChk(`UCS_OFF_IFLAG, 8'h43, rOk);
	print_verdict;
end
endmodule
